//--- wdt_rst_pkg.sv
// Constants, register layout and types for the watchdog and reset control block
// Summary of operation
// RULE1 - Counter advances only on slow oscillator edges
// RULE2 - Three-bit select picks overflow period power
// RULE3 - Guard 10101 disables, 01010 enables watchdog
// RULE4 - Other guard values reset after delay
// RULE5 - Control register powers up 01010_011
// RULE6 - Guard reset sets flag; software clears
// RULE7 - Running overflow gives full reset, timeout flag
// RULE8 - Low-power overflow resets only PC, SP
// RULE9 - Guard reset, clear, halt zero the count
// RULE10 - Bad reset-guard pattern resets after delay
// RULE11 - Reset guard register powers up 01010101
// RULE12 - Program counter starts at zero
// RULE13 - Port data and control power up high
// RULE14 - Upper four flag bits read zero
// RULE15 - Reset-guard reset sets flag; software clears
// RULE16 - Halt clears count; resumes only if enabled
// RULE17 - Software reset delay is clock-cycle parameter
// RULE18 - Slow clock crosses safely before counting
package wdt_rst_pkg;

	typedef struct packed {
		logic [4:0] guard;
		logic [2:0] sel;
	} watchdog_control_t;

	typedef struct packed {
		logic reset_ctrl_reset_flag;
		logic low_voltage_reset_flag;
		logic voltage_select_reset_flag;
		logic watchdog_reg_reset_flag;
	} rst_flags_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'h1,
		ST_DELAY = 2'h2
	} sreset_state_t;

	// Word indices on the register bus
	localparam logic [2:0] OFS_WATCHDOG_CONTROL = 3'h0;
	localparam logic [2:0] OFS_RESET_CAUSE_FLAGS = 3'h1;
	localparam logic [2:0] OFS_RESET_GUARD_PATTERN = 3'h2;
	localparam logic [2:0] OFS_CPU_STATUS = 3'h3;
	localparam logic [2:0] OFS_IRQ_STATUS = 3'h4;
	localparam logic [2:0] OFS_IRQ_CLEAR = 3'h5;
	localparam logic [2:0] OFS_IRQ_ENABLE = 3'h6;

	localparam logic [4:0] GUARD_DISABLE = 5'h15;
	localparam logic [4:0] GUARD_ENABLE = 5'h0A;
	localparam logic [7:0] RESET_GUARD_PATTERN_PAT_A = 8'h55;
	localparam logic [7:0] RESET_GUARD_PATTERN_PAT_B = 8'hAA;

	localparam watchdog_control_t WATCHDOG_CONTROL_POR = '{guard: 5'h0A, sel: 3'h3};
	localparam logic [7:0] RESET_GUARD_PATTERN_POR = 8'h55;
	localparam rst_flags_t FLAGS_POR = '{reset_ctrl_reset_flag: 1'b0, low_voltage_reset_flag: 1'b0, voltage_select_reset_flag: 1'b0, watchdog_reg_reset_flag: 1'b0};

	// Overflow period exponents, indexed by timeout select
	localparam int CNT_W = 18;
	localparam logic [4:0] TO_SHIFT [8] = '{5'h08, 5'h0A, 5'h0C, 5'h0E,
		5'h0F, 5'h10, 5'h11, 5'h12};

	localparam int SRESET_CYCLES = 16;
	localparam int IRQ_W = 3;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_WATCHDOG_CONTROL_RST = 1;
	localparam int IRQ_RESET_GUARD_PATTERN_RST = 2;
	localparam int PORT_W = 8;

endpackage

//--- wdt_rst_ctrl.sv
// Watchdog timer, guard-pattern resets and reset-cause flags with Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module wdt_rst_ctrl #(
	parameter int SRESET_CYCLES = wdt_rst_pkg::SRESET_CYCLES,
	parameter int PORT_W = wdt_rst_pkg::PORT_W
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic slow_osc_clock,
	input wire logic clear_watchdog_instruction,
	input wire logic halt_instruction,
	input wire logic low_power_mode,
	output logic device_reset,
	output logic pc_sp_reset,
	output logic [15:0] pc_start_addr,
	output logic [PORT_W-1:0] io_port_data,
	output logic [PORT_W-1:0] io_port_ctrl,
	output logic timeout_status_flag,
	output logic power_down_flag,
	output logic irq
);

	if (SRESET_CYCLES < 1 || SRESET_CYCLES > 65535) begin : g_chk_delay
		$error("SRESET_CYCLES out of range");
	end
	if (PORT_W < 1 || PORT_W > 32) begin : g_chk_port
		$error("PORT_W out of range");
	end

	function automatic logic [wdt_rst_pkg::CNT_W-1:0] period_limit(input logic [2:0] sel);
		logic [wdt_rst_pkg::CNT_W:0] one_hot;
		one_hot = (wdt_rst_pkg::CNT_W+1)'(1) << wdt_rst_pkg::TO_SHIFT[sel];
		period_limit = wdt_rst_pkg::CNT_W'(one_hot - (wdt_rst_pkg::CNT_W+1)'(1));
	endfunction

	function automatic logic guard_bad(input logic [4:0] g);
		guard_bad = (g != wdt_rst_pkg::GUARD_ENABLE) && (g != wdt_rst_pkg::GUARD_DISABLE);
	endfunction

	function automatic logic reset_guard_pattern_bad(input logic [7:0] p);
		reset_guard_pattern_bad = (p != wdt_rst_pkg::RESET_GUARD_PATTERN_PAT_A) && (p != wdt_rst_pkg::RESET_GUARD_PATTERN_PAT_B);
	endfunction

	wdt_rst_pkg::watchdog_control_t watchdog_control_q;
	logic [7:0] reset_guard_pattern_q;
	wdt_rst_pkg::rst_flags_t flags_q;
	logic to_q;
	logic pdf_q;
	logic [wdt_rst_pkg::IRQ_W-1:0] irq_stat_q;
	logic [wdt_rst_pkg::IRQ_W-1:0] irq_en_q;
	logic [wdt_rst_pkg::CNT_W-1:0] cnt_q;
	logic slow_sync1_q;
	logic slow_sync2_q;
	logic slow_prev_q;
	logic ack_q;
	logic [31:0] rdata_q;
	wdt_rst_pkg::sreset_state_t state_q;
	logic [15:0] delay_cnt_q;
	logic pend_watchdog_control_q;
	logic pend_reset_guard_pattern_q;
	logic dev_rst_q;
	logic pcsp_q;
	logic [PORT_W-1:0] port_data_q;
	logic [PORT_W-1:0] port_ctrl_q;

	logic tick;
	logic wdt_en;
	logic overflow;
	logic wdt_clear;
	logic soft_fire;
	logic full_rst;
	logic wr_fire;
	logic wr_lane0;
	logic watchdog_control_bad_now;
	logic reset_guard_pattern_bad_now;
	logic [wdt_rst_pkg::IRQ_W-1:0] irq_evt;

	// RULE18 two-flop synchroniser
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slow_sync1_q <= 1'b0;
			slow_sync2_q <= 1'b0;
			slow_prev_q <= 1'b0;
		end else begin
			slow_sync1_q <= slow_osc_clock;
			slow_sync2_q <= slow_sync1_q;
			slow_prev_q <= slow_sync2_q;
		end
	end

	// RULE1 rising slow edges
	assign tick = slow_sync2_q & ~slow_prev_q;

	// RULE3 guard enables
	assign wdt_en = (watchdog_control_q.guard == wdt_rst_pkg::GUARD_ENABLE);
	assign watchdog_control_bad_now = guard_bad(watchdog_control_q.guard);
	assign reset_guard_pattern_bad_now = reset_guard_pattern_bad(reset_guard_pattern_q);

	// RULE2 selected overflow period
	assign overflow = wdt_en & tick & (cnt_q == period_limit(watchdog_control_q.sel));

	// RULE9 three clear sources
	assign wdt_clear = clear_watchdog_instruction | halt_instruction | watchdog_control_bad_now;

	// RULE7 full reset on running overflow
	assign full_rst = soft_fire | (overflow & ~low_power_mode);

	// RULE16 halt clears, counting only if enabled
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (wdt_clear || full_rst || overflow) begin
			cnt_q <= '0;
		end else if (wdt_en && tick) begin
			cnt_q <= cnt_q + wdt_rst_pkg::CNT_W'(1);
		end
	end

	// RULE17 delayed software reset
	assign soft_fire = (state_q == wdt_rst_pkg::ST_DELAY) &&
		(delay_cnt_q == 16'(SRESET_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= wdt_rst_pkg::ST_RUN;
			delay_cnt_q <= '0;
			pend_watchdog_control_q <= 1'b0;
			pend_reset_guard_pattern_q <= 1'b0;
		end else begin
			unique case (state_q)
				wdt_rst_pkg::ST_RUN: begin
					delay_cnt_q <= '0;
					// RULE4 RULE10 bad guard starts delay
					if (watchdog_control_bad_now || reset_guard_pattern_bad_now) begin
						state_q <= wdt_rst_pkg::ST_DELAY;
						pend_watchdog_control_q <= watchdog_control_bad_now;
						pend_reset_guard_pattern_q <= reset_guard_pattern_bad_now;
					end
				end
				wdt_rst_pkg::ST_DELAY: begin
					pend_watchdog_control_q <= pend_watchdog_control_q | watchdog_control_bad_now;
					pend_reset_guard_pattern_q <= pend_reset_guard_pattern_q | reset_guard_pattern_bad_now;
					delay_cnt_q <= delay_cnt_q + 16'h0001;
					if (soft_fire) begin
						state_q <= wdt_rst_pkg::ST_RUN;
						pend_watchdog_control_q <= 1'b0;
						pend_reset_guard_pattern_q <= 1'b0;
						delay_cnt_q <= '0;
					end
				end
				default: begin
					state_q <= wdt_rst_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Reset pulses towards the core
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dev_rst_q <= 1'b0;
			pcsp_q <= 1'b0;
		end else begin
			dev_rst_q <= full_rst;
			// RULE8 low-power overflow
			pcsp_q <= overflow & low_power_mode;
		end
	end

	// RULE12 start address zero
	assign pc_start_addr = 16'h0000;
	assign device_reset = dev_rst_q;
	assign pc_sp_reset = pcsp_q;

	// RULE13 ports preset high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port_data_q <= '1;
			port_ctrl_q <= '1;
		end else if (full_rst) begin
			port_data_q <= '1;
			port_ctrl_q <= '1;
		end
	end
	assign io_port_data = port_data_q;
	assign io_port_ctrl = port_ctrl_q;

	// Bus handshake: one wait cycle per access
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_fire = avs_write & ack_q;
	assign wr_lane0 = wr_fire & avs_byteenable[0];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// RULE5 RULE11 guard registers at power-up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_control_q <= wdt_rst_pkg::WATCHDOG_CONTROL_POR;
			reset_guard_pattern_q <= wdt_rst_pkg::RESET_GUARD_PATTERN_POR;
		end else if (full_rst) begin
			watchdog_control_q <= wdt_rst_pkg::WATCHDOG_CONTROL_POR;
			reset_guard_pattern_q <= wdt_rst_pkg::RESET_GUARD_PATTERN_POR;
		end else if (wr_lane0) begin
			if (avs_address == wdt_rst_pkg::OFS_WATCHDOG_CONTROL) begin
				watchdog_control_q <= avs_writedata[7:0];
			end
			if (avs_address == wdt_rst_pkg::OFS_RESET_GUARD_PATTERN) begin
				reset_guard_pattern_q <= avs_writedata[7:0];
			end
		end
	end

	// RULE6 RULE15 set wins over software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_q <= wdt_rst_pkg::FLAGS_POR;
		end else begin
			if (wr_lane0 && avs_address == wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS) begin
				flags_q <= avs_writedata[3:0];
			end
			if (soft_fire && pend_watchdog_control_q) begin
				flags_q.watchdog_reg_reset_flag <= 1'b1;
			end
			if (soft_fire && pend_reset_guard_pattern_q) begin
				flags_q.reset_ctrl_reset_flag <= 1'b1;
			end
		end
	end

	// RULE7 RULE8 timeout flag, power-down flag
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			to_q <= 1'b0;
			pdf_q <= 1'b0;
		end else begin
			if (halt_instruction) begin
				pdf_q <= 1'b1;
				to_q <= 1'b0;
			end else if (clear_watchdog_instruction) begin
				pdf_q <= 1'b0;
			end
			if (overflow) begin
				to_q <= 1'b1;
			end
		end
	end
	assign timeout_status_flag = to_q;
	assign power_down_flag = pdf_q;

	// Interrupt status, enable and clear
	always_comb begin
		irq_evt = '0;
		irq_evt[wdt_rst_pkg::IRQ_OVF] = overflow;
		irq_evt[wdt_rst_pkg::IRQ_WATCHDOG_CONTROL_RST] = soft_fire & pend_watchdog_control_q;
		irq_evt[wdt_rst_pkg::IRQ_RESET_GUARD_PATTERN_RST] = soft_fire & pend_reset_guard_pattern_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			if (wr_lane0 && avs_address == wdt_rst_pkg::OFS_IRQ_CLEAR) begin
				irq_stat_q <= (irq_stat_q & ~avs_writedata[wdt_rst_pkg::IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_q <= irq_stat_q | irq_evt;
			end
			if (wr_lane0 && avs_address == wdt_rst_pkg::OFS_IRQ_ENABLE) begin
				irq_en_q <= avs_writedata[wdt_rst_pkg::IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	// RULE14 upper flag bits read zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= '0;
		end else if (avs_read && !ack_q) begin
			unique case (avs_address)
				wdt_rst_pkg::OFS_WATCHDOG_CONTROL: rdata_q <= {24'h000000, watchdog_control_q};
				wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS: rdata_q <= {28'h0000000, flags_q};
				wdt_rst_pkg::OFS_RESET_GUARD_PATTERN: rdata_q <= {24'h000000, reset_guard_pattern_q};
				wdt_rst_pkg::OFS_CPU_STATUS: rdata_q <= {30'h0, pdf_q, to_q};
				wdt_rst_pkg::OFS_IRQ_STATUS: rdata_q <= {29'h0, irq_stat_q};
				wdt_rst_pkg::OFS_IRQ_ENABLE: rdata_q <= {29'h0, irq_en_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end
	assign avs_readdata = rdata_q;

	// Assertions
	int unsigned hold_cnt;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt <= 0;
		end else if (state_q == wdt_rst_pkg::ST_DELAY) begin
			hold_cnt <= hold_cnt + 1;
		end else begin
			hold_cnt <= 0;
		end
	end

	sequence s_bad_guard;
		(state_q == wdt_rst_pkg::ST_RUN) && watchdog_control_bad_now;
	endsequence

	sequence s_delay_enter;
		##1 (state_q == wdt_rst_pkg::ST_DELAY) && pend_watchdog_control_q;
	endsequence

	AST_CNT_ONLY_ON_TICK: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
		(cnt_q != $past(cnt_q)) |-> $past(tick || wdt_clear || full_rst))
		else $error("count moved without slow edge or clear");

	AST_OVF_AT_LIMIT: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
		overflow |-> ((32'(cnt_q) + 32'h00000001) == (32'h00000001 << wdt_rst_pkg::TO_SHIFT[watchdog_control_q.sel])))
		else $error("overflow away from selected limit");

	AST_DISABLED_STOPS: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
		(watchdog_control_q.guard == wdt_rst_pkg::GUARD_DISABLE) && !wdt_clear && !full_rst
		|=> (cnt_q == $past(cnt_q)))
		else $error("count moved while disabled");

	AST_BAD_GUARD_DELAY: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
		s_bad_guard |-> s_delay_enter)
		else $error("bad guard did not start delay");

	AST_WRF_SETS: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
		(soft_fire && pend_watchdog_control_q) |=> flags_q.watchdog_reg_reset_flag && device_reset)
		else $error("guard reset flag not set");

	AST_FULL_RESET: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
		(overflow && !low_power_mode) |=> device_reset && timeout_status_flag)
		else $error("running overflow missed full reset");

	AST_LOWPOWER_PCSP: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
		(overflow && low_power_mode && !soft_fire) |=> pc_sp_reset && !device_reset
		&& timeout_status_flag)
		else $error("low-power overflow wrong reset");

	AST_HALT_CLEARS: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
		halt_instruction |=> (cnt_q == '0))
		else $error("halt did not clear count");

	AST_RESET_GUARD_PATTERN_DELAY: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
		((state_q == wdt_rst_pkg::ST_RUN) && reset_guard_pattern_bad_now) |=> pend_reset_guard_pattern_q)
		else $error("bad reset guard not latched");

	AST_DELAY_LENGTH: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
		soft_fire |-> (hold_cnt == SRESET_CYCLES - 1))
		else $error("software reset delay wrong length");

	AST_RESET_CTRL_RESET_FLAG_SETS: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
		(soft_fire && pend_reset_guard_pattern_q) |=> flags_q.reset_ctrl_reset_flag)
		else $error("reset guard flag not set");

	AST_FLAGS_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
		(avs_read && !avs_waitrequest && avs_address == wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS)
		|-> (avs_readdata[7:4] == 4'h0))
		else $error("upper flag bits not zero");

endmodule // wdt_rst_ctrl
`default_nettype wire

//--- cpu_core_model.sv
// CPU core model issuing clear-watchdog and halt instruction pulses
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic want_clear,
	input wire logic want_halt,
	output logic clear_pulse,
	output logic halt_pulse
);
	logic [1:0] prev_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= 2'h0;
			clear_pulse <= 1'b0;
			halt_pulse <= 1'b0;
		end else begin
			prev_q <= {want_halt, want_clear};
			clear_pulse <= want_clear & ~prev_q[0];
			halt_pulse <= want_halt & ~prev_q[1];
		end
	end
endmodule // cpu_core_model
`default_nettype wire

//--- test_watchdog_and_reset_control.sv
// Testbench for the watchdog and reset control block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_and_reset_control;
	localparam int SR = 4;
	logic clk = 1'b0;
	logic rst_b, avs_read, avs_write, slow, slow_run, slow_div, lp, want_clear, want_halt;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest, dev_rst, pcsp_rst, clr_p, halt_p, to_flag, pd_flag, irq;
	logic [15:0] pc0;
	logic [7:0] pdat, pctl;
	int n_mismatch, n_checks, n_dev, n_pcsp, took, base;

	wdt_rst_ctrl #(.SRESET_CYCLES(SR), .PORT_W(8)) wdt_rst_ctrl_i (
		.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .slow_osc_clock(slow),
		.clear_watchdog_instruction(clr_p), .halt_instruction(halt_p),
		.low_power_mode(lp), .device_reset(dev_rst), .pc_sp_reset(pcsp_rst),
		.pc_start_addr(pc0), .io_port_data(pdat), .io_port_ctrl(pctl),
		.timeout_status_flag(to_flag), .power_down_flag(pd_flag), .irq(irq)
	);

	cpu_core_model cpu_core_model_i (
		.clk(clk), .rst_b(rst_b), .want_clear(want_clear), .want_halt(want_halt),
		.clear_pulse(clr_p), .halt_pulse(halt_p)
	);

	always #2 clk = ~clk;
	// Slow clock stands still unless a test runs it
	always @(posedge clk) begin
		if (slow_run) begin
			slow_div <= ~slow_div;
			if (slow_div) slow <= ~slow;
		end
	end
	always @(posedge clk) begin
		if (dev_rst === 1'b1) n_dev++;
		if (pcsp_rst === 1'b1) n_pcsp++;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic fail(input string m);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, m);
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) fail($sformatf("bit %b expected %b", got, exp));
	endtask

	task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				fail("bus timeout");
				end_of_test();
			end
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk32(rd, {24'h0, e});
	endtask

	task automatic wait_rst(input bit pc, input int bound);
		int b;
		b = pc ? n_pcsp : n_dev;
		took = 0;
		while ((pc ? n_pcsp : n_dev) == b) begin
			@(negedge clk);
			took++;
			if (took > bound) begin
				fail("reset timeout");
				end_of_test();
			end
		end
	endtask

	task automatic instr(input bit h);
		@(posedge clk);
		if (h) want_halt <= 1'b1;
		else want_clear <= 1'b1;
		@(posedge clk);
		want_halt <= 1'b0;
		want_clear <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic irq_is(input logic e);
		@(negedge clk);
		chk1(irq, e);
	endtask

	initial begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		slow = 1'b0;
		slow_run = 1'b0;
		slow_div = 1'b0;
		lp = 1'b0;
		want_clear = 1'b0;
		want_halt = 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rchk(wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h53);
		rchk(wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'h55);
		// Write without lane 0 is ignored
		avs_byteenable <= 4'hE;
		bus(1'b1, wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'h12);
		avs_byteenable <= 4'hF;
		rchk(wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'h55);
		chk32({16'h0, pc0}, 32'h0);
		chk1(&{pdat, pctl}, 1'b1);
		bus(1'b1, wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'hFF);
		rchk(wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'h0F);
		bus(1'b1, wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'h00);
		// Shortest period overflow while running
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h50);
		slow_run <= 1'b1;
		wait_rst(1'b0, 1500);
		chk1(took >= 1000 && took <= 1050, 1'b1);
		rchk(wdt_rst_pkg::OFS_CPU_STATUS, 8'h01);
		chk1(to_flag, 1'b1);
		rchk(wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h53);
		// Regular clears and the disable guard hold off overflow
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h50);
		base = n_dev;
		repeat (8) begin
			repeat (300) @(posedge clk);
			instr(1'b0);
		end
		chk1(n_dev == base, 1'b1);
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'hA8);
		base = n_dev;
		repeat (1500) @(posedge clk);
		chk1(n_dev == base, 1'b1);
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h50);
		wait_rst(1'b0, 1500);
		// Halt, then overflow in low power
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h50);
		lp <= 1'b1;
		instr(1'b1);
		rchk(wdt_rst_pkg::OFS_CPU_STATUS, 8'h02);
		chk1(pd_flag, 1'b1);
		base = n_dev;
		wait_rst(1'b1, 1500);
		chk1(n_dev == base, 1'b1);
		rchk(wdt_rst_pkg::OFS_CPU_STATUS, 8'h03);
		rchk(wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h50);
		lp <= 1'b0;
		slow_run <= 1'b0;
		instr(1'b0);
		rchk(wdt_rst_pkg::OFS_CPU_STATUS, 8'h01);
		// Corrupted watchdog guard field
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h13);
		wait_rst(1'b0, 40);
		chk1(took >= SR && took <= SR + 3, 1'b1);
		rchk(wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'h01);
		rchk(wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h53);
		bus(1'b1, wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'h00);
		rchk(wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'h00);
		// Reset guard pattern, valid then corrupted
		bus(1'b1, wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'hAA);
		base = n_dev;
		repeat (3 * SR) @(posedge clk);
		rchk(wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'hAA);
		chk1(n_dev == base, 1'b1);
		bus(1'b1, wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'h12);
		wait_rst(1'b0, 40);
		chk1(took >= SR && took <= SR + 3, 1'b1);
		rchk(wdt_rst_pkg::OFS_RESET_CAUSE_FLAGS, 8'h08);
		rchk(wdt_rst_pkg::OFS_RESET_GUARD_PATTERN, 8'h55);
		// Interrupt status, mask and clear
		rchk(wdt_rst_pkg::OFS_IRQ_STATUS, 8'h07);
		bus(1'b1, wdt_rst_pkg::OFS_IRQ_ENABLE, 8'h00);
		irq_is(1'b0);
		bus(1'b1, wdt_rst_pkg::OFS_IRQ_ENABLE, 8'h04);
		irq_is(1'b1);
		bus(1'b1, wdt_rst_pkg::OFS_IRQ_CLEAR, 8'h07);
		irq_is(1'b0);
		rchk(wdt_rst_pkg::OFS_IRQ_STATUS, 8'h00);
		rchk(wdt_rst_pkg::OFS_IRQ_CLEAR, 8'h00);
		rchk(3'h7, 8'h00);
		// Reset in mid-run restores power-up values
		bus(1'b1, wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h50);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rchk(wdt_rst_pkg::OFS_WATCHDOG_CONTROL, 8'h53);
		chk1(&{pdat, pctl}, 1'b1);
		end_of_test();
	end
endmodule // test_watchdog_and_reset_control
`default_nettype wire
